// *** src/drt_pkg.sv ***
// Purpose: shared constants and types of the dual reload down timer
// Assumes: register index times four gives the APB byte address
// Notes: widths are fixed; no parameters override these values
package drt_pkg;
	localparam int DRT_AW = 18;
	localparam int DRT_DW = 32;
	// register indices; byte address is four times the index
	localparam logic [15:0] DRT_IDX_PRESCALE = 16'hff10;
	localparam logic [15:0] DRT_IDX_OSC_SEL = 16'hff12;
	localparam logic [15:0] DRT_IDX_EV_GATES = 16'hff15;
	localparam logic [15:0] DRT_IDX_CH0_CTL = 16'hff30;
	localparam logic [15:0] DRT_IDX_CH1_CTL = 16'hff31;
	localparam logic [15:0] DRT_IDX_CH0_RELOAD = 16'hff32;
	localparam logic [15:0] DRT_IDX_CH1_RELOAD = 16'hff33;
	localparam logic [15:0] DRT_IDX_CH0_CMP = 16'hff34;
	localparam logic [15:0] DRT_IDX_CH1_CMP = 16'hff35;
	localparam logic [15:0] DRT_IDX_CH0_CNT = 16'hff36;
	localparam logic [15:0] DRT_IDX_CH1_CNT = 16'hff37;
	localparam logic [15:0] DRT_IDX_FLAGS = 16'hff38;
	localparam logic [15:0] DRT_IDX_PIN_FLOAT = 16'hffd4;
	localparam logic [15:0] DRT_IDX_PIN_DATA = 16'hffd9;
	// control register fields
	localparam int DRT_MODE_BIT = 7;
	localparam int DRT_RUN_BIT = 2;
	localparam int DRT_PSET_BIT = 1;
	localparam int DRT_CKSEL_BIT = 0;
	// prescale register: one nibble per channel, ratio in low three bits, gate on top
	localparam int DRT_PRE_NIB = 4;
	localparam int DRT_PRE_GATE = 3;
	// reset values
	localparam logic [7:0] DRT_RELOAD_RST = 8'hff;
	localparam logic [7:0] DRT_CMP_RST = 8'h00;
	localparam logic [7:0] DRT_CNT_RST = 8'hff;
	localparam logic [7:0] DRT_PRE_RST = 8'h00;
	localparam logic [2:0] DRT_PIN_RST = 3'h7;
	// synchroniser lanes
	localparam int DRT_NSYN = 4;
	localparam int DRT_SYN_SLOW = 0;
	localparam int DRT_SYN_FAST = 1;
	localparam int DRT_SYN_EV = 2;
	// division ratio minus one, indexed by the ratio code
	localparam logic [7:0][11:0] DRT_FAST_M1 = {12'hfff, 12'h3ff, 12'h0ff, 12'h07f,
		12'h03f, 12'h01f, 12'h007, 12'h001};
	localparam logic [7:0][11:0] DRT_SLOW_M1 = {12'h07f, 12'h03f, 12'h01f, 12'h00f,
		12'h007, 12'h003, 12'h001, 12'h000};
	typedef struct packed {
		logic cksel;
		logic slow;
		logic [2:0] ratio;
		logic pgate;
		logic egate;
		logic run;
	} drt_chan_cfg_t;
endpackage : drt_pkg

// *** src/drt_timer.sv ***
// Purpose: two 8-bit reload down counters, cascadable to one 16-bit counter, APB slave
// Assumes: oscillators and event pins are asynchronous to sys_clk and far slower
// Notes: counters advance on the rising edge of the synchronised source
// Functional notes
// - width mode bit: 0 two 8-bit channels, 1 one 16-bit; resets to 0
// - input clock select: 0 prescaled clock, 1 external event input; resets 0
// - in 16-bit mode channel 1 select ignored; channel 0 source drives counter
// - source oscillator bit: 1 slow oscillator, 0 fast; resets to fast
// - 3-bit readable prescale ratio per channel, eight ratios, resets to zero
// - codes divide fast by 2..4096, slow by 1..128
// - prescale gate passes prescaled clock only while set; resets cleared
// - event gate passes event pin only while set; resets cleared
// - counter loads reload value on preset strobe and on underflow
// - compare match asserted while counter equals compare value; drives flag and wave
// - wave rises after underflow, falls after match; high if reload not above compare
// - counter registers are read-only and readable any time
// - low byte read does not latch high byte; software stops timer first
// - preset restarts running counter at once; stopped counter holds preset value
// - preset acts on write of 1 only and always reads 0
// - in 16-bit mode channel 1 preset ignored; channel 0 loads full 16 bits
// - run bit 1 counts down, 0 stops; reads back its state
// - stopped counter holds value and resumes from it on restart
// - in 16-bit mode channel 0 run controls both; channel 1 run held 0
// - 16-bit: channel 0 flags never set; channel 1 flags follow combined counter
// - float bits: 1 pin floats, 0 pin driven; reset to 1
// - pin data bits drive pin level; reset to 1; upper bits read 0
//
// Register access over APB was decided locally.
`timescale 1ns/1ps
module drt_timer (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [drt_pkg::DRT_AW-1:0] paddr,
	input wire logic [drt_pkg::DRT_DW-1:0] pwdata,
	output logic [drt_pkg::DRT_DW-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic slow_oscillator,
	input wire logic fast_oscillator,
	input wire logic ch0_event_pin,
	input wire logic ch1_event_pin,
	output logic [1:0] timer_wave_out,
	output logic [2:0] pin_out,
	output logic [2:0] pin_oe
);
	logic [7:0] pre_ctl;
	logic [1:0] osc_sel;
	logic [1:0] ev_gate;
	logic width_mode_select;
	logic [1:0] run_ctl;
	logic [1:0] cksel;
	logic [1:0][7:0] reload;
	logic [1:0][7:0] cmp;
	logic [1:0][7:0] cnt;
	logic [3:0] flags;
	logic [2:0] pin_float;
	logic [2:0] pin_data;
	logic [1:0] match_q;
	logic [1:0] uf_q;
	logic [drt_pkg::DRT_NSYN-1:0] syn1;
	logic [drt_pkg::DRT_NSYN-1:0] syn2;
	logic [drt_pkg::DRT_NSYN-1:0] syn3;
	logic [drt_pkg::DRT_NSYN-1:0] rise;
	drt_pkg::drt_chan_cfg_t [1:0] cfg;
	logic [1:0] src_tick;

	// bus decode
	wire [15:0] idx = paddr[drt_pkg::DRT_AW-1:2];
	wire access = psel & penable;
	wire wr = access & pwrite & pready;
	wire [7:0] wd = pwdata[7:0];
	wire hit_pre = idx == drt_pkg::DRT_IDX_PRESCALE;
	wire hit_osc = idx == drt_pkg::DRT_IDX_OSC_SEL;
	wire hit_evg = idx == drt_pkg::DRT_IDX_EV_GATES;
	wire hit_c0 = idx == drt_pkg::DRT_IDX_CH0_CTL;
	wire hit_c1 = idx == drt_pkg::DRT_IDX_CH1_CTL;
	wire hit_r0 = idx == drt_pkg::DRT_IDX_CH0_RELOAD;
	wire hit_r1 = idx == drt_pkg::DRT_IDX_CH1_RELOAD;
	wire hit_m0 = idx == drt_pkg::DRT_IDX_CH0_CMP;
	wire hit_m1 = idx == drt_pkg::DRT_IDX_CH1_CMP;
	wire hit_n0 = idx == drt_pkg::DRT_IDX_CH0_CNT;
	wire hit_n1 = idx == drt_pkg::DRT_IDX_CH1_CNT;
	wire hit_fl = idx == drt_pkg::DRT_IDX_FLAGS;
	wire hit_pf = idx == drt_pkg::DRT_IDX_PIN_FLOAT;
	wire hit_pd = idx == drt_pkg::DRT_IDX_PIN_DATA;
	wire mapped = hit_pre | hit_osc | hit_evg | hit_c0 | hit_c1 | hit_r0 | hit_r1 | hit_m0 | hit_m1
		| hit_n0 | hit_n1 | hit_fl | hit_pf | hit_pd;
	wire m16 = width_mode_select;
	// a write of 0 to the strobe does nothing
	wire ch0_preset_strobe = wr & hit_c0 & wd[drt_pkg::DRT_PSET_BIT];
	wire ch1_preset_strobe = wr & hit_c1 & wd[drt_pkg::DRT_PSET_BIT] & ~m16;

	// strobe bits and the unused control bits read as zero
	wire [7:0] rd_c0 = {width_mode_select, 4'h0, run_ctl[0], 1'b0, cksel[0]};
	wire [7:0] rd_c1 = {5'h00, run_ctl[1], 1'b0, cksel[1]};
	wire [7:0] rd_data = ({8{hit_pre}} & pre_ctl)
		| ({8{hit_osc}} & {6'h00, osc_sel})
		| ({8{hit_evg}} & {6'h00, ev_gate})
		| ({8{hit_c0}} & rd_c0)
		| ({8{hit_c1}} & rd_c1)
		| ({8{hit_r0}} & reload[0])
		| ({8{hit_r1}} & reload[1])
		| ({8{hit_m0}} & cmp[0])
		| ({8{hit_m1}} & cmp[1])
		| ({8{hit_n0}} & cnt[0])
		| ({8{hit_n1}} & cnt[1])
		| ({8{hit_fl}} & {4'h0, flags})
		| ({8{hit_pf}} & {5'h00, pin_float})
		| ({8{hit_pd}} & {5'h00, pin_data});

	// one wait state: ready rises in the second access cycle
	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
		end
		else
		begin
			pready <= access & ~pready;
			pslverr <= access & ~pready & ~mapped;
			prdata <= (access & ~pready & ~pwrite) ? {24'h000000, rd_data} : '0;
		end
	end

	// input synchronisers; only syn2 feeds logic, syn3 is the edge history
	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			syn1 <= '0;
			syn2 <= '0;
			syn3 <= '0;
		end
		else
		begin
			syn1 <= {ch1_event_pin, ch0_event_pin, fast_oscillator, slow_oscillator};
			syn2 <= syn1;
			syn3 <= syn2;
		end
	end
	assign rise = syn2 & ~syn3;

	assign cfg[0] = {cksel[0], osc_sel[0], pre_ctl[2:0], pre_ctl[drt_pkg::DRT_PRE_GATE], ev_gate[0], run_ctl[0]};
	assign cfg[1] = {cksel[1], osc_sel[1], pre_ctl[drt_pkg::DRT_PRE_NIB +: 3],
		pre_ctl[drt_pkg::DRT_PRE_NIB + drt_pkg::DRT_PRE_GATE], ev_gate[1], run_ctl[1]};

	// per channel prescaler and source selection
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++)
		begin : g_chan
			logic [11:0] div;
			wire osc_edge = cfg[gi].slow ? rise[drt_pkg::DRT_SYN_SLOW] : rise[drt_pkg::DRT_SYN_FAST];
			wire [11:0] lim = cfg[gi].slow ? drt_pkg::DRT_SLOW_M1[cfg[gi].ratio]
				: drt_pkg::DRT_FAST_M1[cfg[gi].ratio];
			wire wrap = div >= lim;
			wire ptick = cfg[gi].pgate & osc_edge & wrap;
			wire etick = cfg[gi].egate & rise[drt_pkg::DRT_SYN_EV + gi];
			assign src_tick[gi] = cfg[gi].cksel ? etick : ptick;
			// a gated-off prescaler restarts its division from zero
			always_ff @(posedge sys_clk or negedge nrst)
			begin
				if (!nrst)
					div <= '0;
				else if (!cfg[gi].pgate)
					div <= '0;
				else if (osc_edge)
					div <= wrap ? 12'h000 : div + 12'h001;
			end
		end
	endgenerate

	// counter next state
	logic [1:0][7:0] next_cnt;
	logic [1:0] uf_ev;
	logic [1:0] match_lvl;
	logic [1:0] fixed_hi;
	logic [15:0] wide;
	always_comb
	begin
		next_cnt = cnt;
		uf_ev = 2'b00;
		wide = {cnt[1], cnt[0]};
		if (m16)
		begin
			// channel 0 is the low byte, so the borrow falls out of the 16-bit decrement
			if (ch0_preset_strobe)
				wide = {reload[1], reload[0]};
			else if (run_ctl[0] & src_tick[0])
			begin
				if (wide == 16'h0000)
				begin
					wide = {reload[1], reload[0]};
					uf_ev[1] = 1'b1;
				end
				else
					wide = wide - 16'h0001;
			end
			next_cnt[1] = wide[15:8];
			next_cnt[0] = wide[7:0];
			match_lvl = {({cnt[1], cnt[0]} == {cmp[1], cmp[0]}), 1'b0};
			fixed_hi = {({reload[1], reload[0]} <= {cmp[1], cmp[0]}), 1'b1};
		end
		else
		begin
			for (int i = 0; i < 2; i++)
			begin
				if (i == 0 ? ch0_preset_strobe : ch1_preset_strobe)
					next_cnt[i] = reload[i];
				else if (run_ctl[i] & src_tick[i])
				begin
					if (cnt[i] == 8'h00)
					begin
						next_cnt[i] = reload[i];
						uf_ev[i] = 1'b1;
					end
					else
						next_cnt[i] = cnt[i] - 8'h01;
				end
			end
			match_lvl = {cnt[1] == cmp[1], cnt[0] == cmp[0]};
			fixed_hi = {reload[1] <= cmp[1], reload[0] <= cmp[0]};
		end
	end

	// hardware set wins over a software clear in the same cycle
	wire [3:0] flag_set = {match_lvl[1] & ~match_q[1], uf_ev[1], match_lvl[0] & ~match_q[0], uf_ev[0]};
	wire [3:0] flag_clr = (wr & hit_fl) ? wd[3:0] : 4'h0;
	wire [3:0] next_flags = (flags & ~flag_clr) | flag_set;
	wire [1:0] uf_fall = uf_q & ~uf_ev;
	wire [1:0] match_fall = match_q & ~match_lvl;

	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			cnt <= {drt_pkg::DRT_CNT_RST, drt_pkg::DRT_CNT_RST};
			flags <= '0;
			match_q <= '0;
			uf_q <= '0;
		end
		else
		begin
			cnt <= next_cnt;
			flags <= next_flags;
			match_q <= match_lvl;
			uf_q <= uf_ev;
		end
	end

	// output wave per channel; in 16-bit mode channel 0 rests high
	generate
		for (gi = 0; gi < 2; gi++)
		begin : g_wave
			always_ff @(posedge sys_clk or negedge nrst)
			begin
				if (!nrst)
					timer_wave_out[gi] <= 1'b0;
				else if (fixed_hi[gi])
					timer_wave_out[gi] <= 1'b1;
				else if (match_fall[gi])
					timer_wave_out[gi] <= 1'b0;
				else if (uf_fall[gi])
					timer_wave_out[gi] <= 1'b1;
			end
		end
	endgenerate

	// configuration registers
	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			pre_ctl <= drt_pkg::DRT_PRE_RST;
			osc_sel <= '0;
			ev_gate <= '0;
			width_mode_select <= 1'b0;
			run_ctl <= '0;
			cksel <= '0;
			reload <= {drt_pkg::DRT_RELOAD_RST, drt_pkg::DRT_RELOAD_RST};
			cmp <= {drt_pkg::DRT_CMP_RST, drt_pkg::DRT_CMP_RST};
		end
		else if (wr)
		begin
			if (hit_pre)
				pre_ctl <= wd;
			if (hit_osc)
				osc_sel <= wd[1:0];
			if (hit_evg)
				ev_gate <= wd[1:0];
			if (hit_c0)
			begin
				width_mode_select <= wd[drt_pkg::DRT_MODE_BIT];
				run_ctl[0] <= wd[drt_pkg::DRT_RUN_BIT];
				cksel[0] <= wd[drt_pkg::DRT_CKSEL_BIT];
				if (wd[drt_pkg::DRT_MODE_BIT])
					run_ctl[1] <= 1'b0;
			end
			if (hit_c1)
			begin
				run_ctl[1] <= wd[drt_pkg::DRT_RUN_BIT] & ~m16;
				cksel[1] <= wd[drt_pkg::DRT_CKSEL_BIT];
			end
			if (hit_r0)
				reload[0] <= wd;
			if (hit_r1)
				reload[1] <= wd;
			if (hit_m0)
				cmp[0] <= wd;
			if (hit_m1)
				cmp[1] <= wd;
		end
	end

	// pin port; enable is registered so every output leaves a flop
	always_ff @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			pin_float <= drt_pkg::DRT_PIN_RST;
			pin_data <= drt_pkg::DRT_PIN_RST;
			pin_out <= drt_pkg::DRT_PIN_RST;
			pin_oe <= 3'h0;
		end
		else
		begin
			if (wr & hit_pf)
				pin_float <= wd[2:0];
			if (wr & hit_pd)
				pin_data <= wd[2:0];
			pin_out <= pin_data;
			pin_oe <= ~pin_float;
		end
	end
endmodule : drt_timer

// *** test/drt_timer_chk.sv ***
// Purpose: port-level checks of the timer's bus answer and pin outputs
// Assumes: one clock domain, sys_clk
// Notes: counting rules are judged by the bench through register reads
`timescale 1ns/1ps
module drt_timer_chk (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [drt_pkg::DRT_AW-1:0] paddr,
	input wire logic [drt_pkg::DRT_DW-1:0] pwdata,
	input wire logic [drt_pkg::DRT_DW-1:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [2:0] pin_out,
	input wire logic [2:0] pin_oe
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	wire logic wr_done = psel && penable && pready && pwrite;
	property p_pulse; pready |=> !pready; endproperty
	a_pulse: assert property (p_pulse) else $error("pready longer than one cycle");
	property p_access; pready |-> $past(psel && penable); endproperty
	a_access: assert property (p_access) else $error("pready without access");
	property p_answer; psel && penable && !pready |-> ##[0:3] pready; endproperty
	a_answer: assert property (p_answer) else $error("no answer to access");
	property p_idle; !pready |-> prdata == 32'h0; endproperty
	a_idle: assert property (p_idle) else $error("read data outside answer");
	property p_upper; prdata[31:8] == 24'h0; endproperty
	a_upper: assert property (p_upper) else $error("upper read bits set");
	property p_err; pslverr |-> pready && prdata == 32'h0; endproperty
	a_err: assert property (p_err) else $error("error answer malformed");
	property p_oe;
		wr_done && paddr[17:2] == drt_pkg::DRT_IDX_PIN_FLOAT |-> ##2 pin_oe == ~$past(pwdata[2:0], 2);
	endproperty
	a_oe: assert property (p_oe) else $error("pin enable not from float bits");
	property p_pin;
		wr_done && paddr[17:2] == drt_pkg::DRT_IDX_PIN_DATA |-> ##2 pin_out == $past(pwdata[2:0], 2);
	endproperty
	a_pin: assert property (p_pin) else $error("pin level not from data bits");
	property p_rst; $rose(nrst) |-> pin_out == 3'h7 && pin_oe == 3'h0; endproperty
	a_rst: assert property (p_rst) else $error("pin reset state wrong");
	c_float: cover property (wr_done && paddr[17:2] == drt_pkg::DRT_IDX_PIN_FLOAT);
	c_err: cover property (pslverr);
	c_read: cover property (pready && !pwrite);
endmodule : drt_timer_chk

// *** test/drt_timer_bench.sv ***
// Purpose: register-level test of the dual reload down timer
// Assumes: clocks and event pins pulsed far slower than sys_clk
// Notes: each source pulse is 4 cycles high and 4 low so the synchroniser sees every edge
`timescale 1ns/1ps
module drt_timer_bench;
	logic sys_clk = 1'b0;
	logic nrst = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [drt_pkg::DRT_AW-1:0] paddr = 18'h0;
	logic [drt_pkg::DRT_DW-1:0] pwdata = 32'h0;
	logic [drt_pkg::DRT_DW-1:0] prdata;
	logic pready;
	logic pslverr;
	logic [3:0] src = 4'h0;
	logic [1:0] timer_wave_out;
	logic [2:0] pin_out;
	logic [2:0] pin_oe;
	logic [7:0] r;
	logic e;
	int err_count = 0;
	int checks = 0;
	int cyc = 0;
	logic [15:0] ri [13] = '{16'hff10, 16'hff12, 16'hff15, 16'hff30, 16'hff31, 16'hff32, 16'hff33,
		16'hff34, 16'hff35, 16'hff36, 16'hff37, 16'hffd4, 16'hffd9};
	logic [7:0] rv [13] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'hff, 8'h00, 8'h00, 8'hff, 8'hff,
		8'h07, 8'h07};
	logic [15:0] wi [7] = '{16'hff10, 16'hff12, 16'hff15, 16'hffd4, 16'hffd9, 16'hff34, 16'hff36};
	logic [7:0] wd [7] = '{8'ha5, 8'hff, 8'hff, 8'h02, 8'h05, 8'h5a, 8'h12};
	logic [7:0] we [7] = '{8'ha5, 8'h03, 8'h03, 8'h02, 8'h05, 8'h5a, 8'hff};
	always #4 sys_clk = ~sys_clk;
	drt_timer i_dut (
		.sys_clk(sys_clk),
		.nrst(nrst),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.slow_oscillator(src[0]),
		.fast_oscillator(src[1]),
		.ch0_event_pin(src[2]),
		.ch1_event_pin(src[3]),
		.timer_wave_out(timer_wave_out),
		.pin_out(pin_out),
		.pin_oe(pin_oe)
	);
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : report_and_stop
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : cmp
	// ends just after the edge that releases the bus, so calls may follow back to back
	task automatic apb(input logic w, input logic [15:0] idx, input logic [7:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= {24'h0, d};
		@(posedge sys_clk);
		penable <= 1'b1;
		@(posedge sys_clk);
		// no local limit: only the bench timeout ends a hung access
		while (pready !== 1'b1)
			@(posedge sys_clk);
		r = prdata[7:0];
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk);
	endtask : apb
	task automatic chk(input logic [15:0] idx, input logic [7:0] exp);
		apb(1'b0, idx, 8'h00);
		cmp(r, exp);
		cmp({7'h0, e}, 8'h00);
	endtask : chk
	task automatic pulse(input int w, input int n);
		repeat (n)
		begin
			src[w] <= 1'b1;
			repeat (4) @(posedge sys_clk);
			src[w] <= 1'b0;
			repeat (4) @(posedge sys_clk);
		end
		repeat (8) @(posedge sys_clk);
	endtask : pulse
	always @(posedge sys_clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			err_count++;
			report_and_stop();
		end
	end
	initial
	begin
		repeat (12) @(posedge sys_clk);
		nrst <= 1'b1;
		for (int i = 0; i < 13; i++)
			chk(ri[i], rv[i]);
		for (int i = 0; i < 7; i++)
		begin
			apb(1'b1, wi[i], wd[i]);
			chk(wi[i], we[i]);
		end
		apb(1'b0, 16'h0000, 8'h00);
		cmp({7'h0, e}, 8'h01);
		apb(1'b1, drt_pkg::DRT_IDX_OSC_SEL, 8'h01);
		for (int c = 0; c < 4; c++)
		begin
			apb(1'b1, drt_pkg::DRT_IDX_PRESCALE, 8'h08 | c[7:0]);
			apb(1'b1, drt_pkg::DRT_IDX_CH0_CTL, 8'h06);
			pulse(1, 16);
			pulse(0, 16);
			apb(1'b1, drt_pkg::DRT_IDX_CH0_CTL, 8'h00);
			chk(drt_pkg::DRT_IDX_CH0_CNT, 8'hff - (8'h10 >> c));
		end
		apb(1'b1, drt_pkg::DRT_IDX_OSC_SEL, 8'h00);
		apb(1'b1, drt_pkg::DRT_IDX_PRESCALE, 8'h08);
		apb(1'b1, drt_pkg::DRT_IDX_CH0_CTL, 8'h06);
		pulse(1, 16);
		apb(1'b1, drt_pkg::DRT_IDX_PRESCALE, 8'h00);
		pulse(1, 16);
		chk(drt_pkg::DRT_IDX_CH0_CNT, 8'hf7);
		apb(1'b1, drt_pkg::DRT_IDX_CH1_RELOAD, 8'h03);
		apb(1'b1, drt_pkg::DRT_IDX_CH1_CMP, 8'h05);
		apb(1'b1, drt_pkg::DRT_IDX_EV_GATES, 8'h02);
		apb(1'b1, drt_pkg::DRT_IDX_CH1_CTL, 8'h07);
		chk(drt_pkg::DRT_IDX_CH1_CTL, 8'h05);
		pulse(3, 5);
		chk(drt_pkg::DRT_IDX_CH1_CNT, 8'h02);
		chk(drt_pkg::DRT_IDX_FLAGS, 8'h04);
		cmp({7'h0, timer_wave_out[1]}, 8'h01);
		apb(1'b1, drt_pkg::DRT_IDX_EV_GATES, 8'h00);
		pulse(3, 3);
		apb(1'b1, drt_pkg::DRT_IDX_CH1_CTL, 8'h01);
		apb(1'b1, drt_pkg::DRT_IDX_EV_GATES, 8'h02);
		pulse(3, 3);
		chk(drt_pkg::DRT_IDX_CH1_CNT, 8'h02);
		apb(1'b1, drt_pkg::DRT_IDX_CH0_RELOAD, 8'h04);
		apb(1'b1, drt_pkg::DRT_IDX_CH0_CMP, 8'h02);
		apb(1'b1, drt_pkg::DRT_IDX_EV_GATES, 8'h01);
		apb(1'b1, drt_pkg::DRT_IDX_CH0_CTL, 8'h07);
		// 04 down to 00 then reload: wave rises after the underflow pulse
		pulse(2, 5);
		cmp({7'h0, timer_wave_out[0]}, 8'h01);
		// 03, 02, 01: wave falls when the match at 02 ends
		pulse(2, 3);
		cmp({7'h0, timer_wave_out[0]}, 8'h00);
		chk(drt_pkg::DRT_IDX_FLAGS, 8'h07);
		apb(1'b1, drt_pkg::DRT_IDX_FLAGS, 8'h0f);
		apb(1'b1, drt_pkg::DRT_IDX_CH0_RELOAD, 8'h00);
		apb(1'b1, drt_pkg::DRT_IDX_CH1_RELOAD, 8'h01);
		apb(1'b1, drt_pkg::DRT_IDX_EV_GATES, 8'h01);
		// mode first, so the preset below already sees 16-bit mode
		apb(1'b1, drt_pkg::DRT_IDX_CH0_CTL, 8'h80);
		apb(1'b1, drt_pkg::DRT_IDX_CH0_CTL, 8'h87);
		apb(1'b1, drt_pkg::DRT_IDX_CH1_CTL, 8'h05);
		chk(drt_pkg::DRT_IDX_CH1_CTL, 8'h01);
		pulse(2, 2);
		apb(1'b1, drt_pkg::DRT_IDX_CH1_CTL, 8'h03);
		apb(1'b1, drt_pkg::DRT_IDX_CH0_CTL, 8'h81);
		chk(drt_pkg::DRT_IDX_CH0_CNT, 8'hfe);
		chk(drt_pkg::DRT_IDX_CH1_CNT, 8'h00);
		chk(drt_pkg::DRT_IDX_FLAGS, 8'h00);
		cmp({7'h0, timer_wave_out[0]}, 8'h01);
		report_and_stop();
	end
endmodule : drt_timer_bench
bind drt_timer drt_timer_chk i_chk (
	.sys_clk(sys_clk),
	.nrst(nrst),
	.psel(psel),
	.penable(penable),
	.pwrite(pwrite),
	.paddr(paddr),
	.pwdata(pwdata),
	.prdata(prdata),
	.pready(pready),
	.pslverr(pslverr),
	.pin_out(pin_out),
	.pin_oe(pin_oe)
);
